// File: rtl/tade_encoder.sv
`timescale 1ns/1ps

module tade_encoder
    import tade_pkg::*;
#(
    parameter int unsigned BIT_CYC = TADE_BIT_CYC
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // host side
    input  wire logic       send_request_line,
    input  wire tade_pins_s pins,
    // weak pull control, one shared direction for all pins
    output tade_pins_s      pull_up_sel,
    // line side
    output tade_line_s      line
);

    localparam logic [31:0] BIT_LAST  = 32'(BIT_CYC - 1);
    localparam logic [31:0] QUARTER   = 32'(BIT_CYC / 4);
    localparam logic [31:0] THREE_Q   = 32'((3 * BIT_CYC) / 4);
    localparam logic [31:0] SENSE_END = 32'(TADE_SENSE_CYC - 1);
    localparam logic [31:0] SYNC_END  = 32'(TADE_SYNC_BITS * BIT_CYC - 1);
    localparam logic [5:0]  SYM_LAST  = 6'(TADE_SYMS - 1);
    localparam logic [1:0]  WORD_LAST = 2'(TADE_WORDS - 1);

    typedef struct packed {
        tade_state_e                  st;
        logic [31:0]                  timer;
        logic [1:0]                   word;
        logic [5:0]                   sym;
        logic                         pull_up;
        logic [TADE_PINS-1:0]         samp_up;
        logic [TADE_SYMS-1:0]         code;
        logic                         tx;
        logic                         active;
    } tade_state_s;

    tade_state_s          s_q;
    tade_state_s          s_d;
    logic [TADE_PINS-1:0] pin_now;
    logic [TADE_SYMS-1:0] code_w;

    // pin order fixes the word order: address 0..9 then payload 0..7
    assign pin_now = {pins.payload, pins.addr};

    // per pin tri-state resolve from the two weak-pull samples
    genvar gi;
    generate
        for (gi = 0; gi < TADE_PINS; gi++) begin : g_trit
            always_comb begin
                if (s_q.samp_up[gi] && !pin_now[gi]) begin
                    code_w[2*gi+1:2*gi] = TADE_TRIT_FLOAT;
                end else if (pin_now[gi]) begin
                    code_w[2*gi+1:2*gi] = TADE_TRIT_HIGH;
                end else begin
                    code_w[2*gi+1:2*gi] = TADE_TRIT_LOW;
                end
            end
            // every pin, so the floating address and payload pins are all covered
            a_float_code: assert property (@(posedge sys_clk) disable iff (rst)
                (s_q.st == TADE_SENSE_DN && s_q.timer == SENSE_END && s_q.samp_up[gi]
                 && !pin_now[gi]) |=> (s_q.code[2*gi+1:2*gi] == TADE_TRIT_FLOAT))
                else $error("floating pin not coded as float");
        end
    endgenerate

    // next state
    always_comb begin
        s_d       = s_q;
        s_d.timer = s_q.timer + 32'h1;
        case (s_q.st)
            TADE_IDLE: begin
                s_d.timer   = '0;
                s_d.tx      = 1'b0;
                s_d.active  = 1'b0;
                s_d.pull_up = 1'b1;
                // level, not edge: a request tied high sends straight out of reset
                if (send_request_line) begin
                    s_d.st     = TADE_SENSE_UP;
                    s_d.active = 1'b1;
                end
            end
            TADE_SENSE_UP: begin
                if (s_q.timer == SENSE_END) begin
                    s_d.samp_up = pin_now;
                    s_d.pull_up = 1'b0;
                    s_d.timer   = '0;
                    s_d.st      = TADE_SENSE_DN;
                end
            end
            TADE_SENSE_DN: begin
                if (s_q.timer == SENSE_END) begin
                    s_d.code    = code_w;
                    s_d.pull_up = 1'b1;
                    s_d.timer   = '0;
                    s_d.word    = '0;
                    s_d.st      = TADE_SYNC;
                end
            end
            TADE_SYNC: begin
                s_d.tx = 1'b0;
                if (s_q.timer == SYNC_END) begin
                    s_d.timer = '0;
                    s_d.sym   = '0;
                    s_d.st    = TADE_BITS;
                    s_d.tx    = 1'b1;
                end
            end
            TADE_BITS: begin
                // a 1 stays high for three quarters of the bit, a 0 for one quarter
                if (s_q.code[s_q.sym]) begin
                    s_d.tx = (s_d.timer < THREE_Q);
                end else begin
                    s_d.tx = (s_d.timer < QUARTER);
                end
                if (s_q.timer == BIT_LAST) begin
                    s_d.timer = '0;
                    s_d.tx    = 1'b1;
                    if (s_q.sym != SYM_LAST) begin
                        s_d.sym = s_q.sym + 6'h1;
                    end else if (s_q.word != WORD_LAST) begin
                        s_d.word = s_q.word + 2'h1;
                        s_d.st   = TADE_SYNC;
                        s_d.tx   = 1'b0;
                    end else if (send_request_line) begin
                        // resample before the next cycle so new inputs get sent
                        s_d.st = TADE_SENSE_UP;
                        s_d.tx = 1'b0;
                    end else begin
                        // request only ends sending at a cycle boundary
                        s_d.st     = TADE_IDLE;
                        s_d.tx     = 1'b0;
                        s_d.active = 1'b0;
                    end
                end
            end
            default: begin
                s_d.st = TADE_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q         <= '0;
            s_q.st      <= TADE_IDLE;
            s_q.pull_up <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign pull_up_sel = {TADE_PINS{s_q.pull_up}};
    assign line.data   = s_q.tx;
    assign line.active = s_q.active;

    // checks
    a_idle_silent: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_IDLE) |-> !line.data && !line.active)
        else $error("line busy while idle");

    a_start_on_req: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_IDLE && send_request_line) |=> (s_q.st == TADE_SENSE_UP)
        && line.active)
        else $error("request did not start a cycle");

    a_power_up_send: assert property (@(posedge sys_clk)
        $fell(rst) && send_request_line |=> (s_q.st == TADE_SENSE_UP))
        else $error("tied-high request not sent after reset");

    a_word_count: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_BITS) |-> (s_q.word <= WORD_LAST) && (s_q.sym <= SYM_LAST))
        else $error("word or symbol count out of range");

    a_word_next: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_BITS && s_q.timer == BIT_LAST && s_q.sym == SYM_LAST
         && s_q.word != WORD_LAST) |=> (s_q.st == TADE_SYNC)
        && (s_q.word == $past(s_q.word) + 2'h1))
        else $error("next word not started");

    a_cycle_repeat: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_BITS && s_q.timer == BIT_LAST && s_q.sym == SYM_LAST
         && s_q.word == WORD_LAST && send_request_line)
        |=> (s_q.st == TADE_SENSE_UP) && line.active)
        else $error("held request did not repeat the cycle");

    // active drops on the same edge as the move to idle; a new request may follow at once
    a_cycle_stop: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_BITS && s_q.timer == BIT_LAST && s_q.sym == SYM_LAST
         && s_q.word == WORD_LAST && !send_request_line)
        |=> (s_q.st == TADE_IDLE) && !line.active && !line.data)
        else $error("cycle did not stop after request fell");

    // anywhere short of the last bit end, a low request must not end the cycle
    a_mid_fall_go: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st != TADE_IDLE && !send_request_line
         && !(s_q.st == TADE_BITS && s_q.timer == BIT_LAST && s_q.sym == SYM_LAST
              && s_q.word == WORD_LAST)) |=> (s_q.st != TADE_IDLE) && line.active)
        else $error("cycle cut short");

    a_data_order: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_SENSE_DN && s_q.timer == SENSE_END && pins.payload[0])
        |=> (s_q.code[2*TADE_ADDR_W+1:2*TADE_ADDR_W] == TADE_TRIT_HIGH))
        else $error("payload bit 0 not after the address");

    a_pull_phase: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.st == TADE_SENSE_DN) |-> (pull_up_sel == '0))
        else $error("pull-down phase drives pull-up");

endmodule : tade_encoder

// File: rtl/tade_pkg.sv
package tade_pkg;

    // pin groups
    localparam int unsigned TADE_ADDR_W  = 10;
    localparam int unsigned TADE_DATA_W  = 8;
    localparam int unsigned TADE_PINS    = TADE_ADDR_W + TADE_DATA_W;
    localparam int unsigned TADE_SYMS    = 2 * TADE_PINS;   // two line bits per trit
    localparam int unsigned TADE_WORDS   = 3;               // words per cycle
    localparam int unsigned TADE_SYNC_BITS = 12;            // silent bit periods before a word

    // trit codes, first line bit in bit 0
    localparam logic [1:0] TADE_TRIT_LOW   = 2'h0;
    localparam logic [1:0] TADE_TRIT_HIGH  = 2'h3;
    localparam logic [1:0] TADE_TRIT_FLOAT = 2'h2;          // sent as 0 then 1

    // timing
    localparam int unsigned TADE_CLK_PS    = 4000;          // 250 MHz
    localparam int unsigned TADE_BIT_NS    = 400000;        // one line bit period
    localparam int unsigned TADE_BIT_CYC   = (TADE_BIT_NS * 1000) / TADE_CLK_PS;
    localparam int unsigned TADE_SENSE_NS  = 1000;          // weak pull settle time
    localparam int unsigned TADE_SENSE_CYC = (TADE_SENSE_NS * 1000 + TADE_CLK_PS - 1)
                                             / TADE_CLK_PS;
    localparam int unsigned TADE_LAG_MS    = 150;           // longest refresh lag

    // tri-state pins as seen at the device
    typedef struct packed {
        logic [TADE_DATA_W-1:0] payload;
        logic [TADE_ADDR_W-1:0] addr;
    } tade_pins_s;

    // line side outputs
    typedef struct packed {
        logic active;   // transmitter keyed on for a cycle
        logic data;     // serial modulation level
    } tade_line_s;

    typedef enum logic [2:0] {
        TADE_IDLE,
        TADE_SENSE_UP,
        TADE_SENSE_DN,
        TADE_SYNC,
        TADE_BITS
    } tade_state_e;

endpackage : tade_pkg

// File: test/tade_encoder_bench.sv
`timescale 1ns/1ps
module tade_encoder_bench;
    import tade_pkg::*;
    logic             sys_clk, rst, req, word_v, match;
    logic [9:0][1:0]  am;
    logic [7:0][1:0]  pm;
    logic [19:0]      loc;
    logic [35:0]      word;
    logic [7:0]       pout;
    tade_pins_s       pins, pull_up_sel;
    tade_line_s       line;
    int               n_mismatch, n_compared, n_words;
    tade_encoder #(.BIT_CYC(8)) dut (.sys_clk(sys_clk), .rst(rst), .send_request_line(req),
        .pins(pins), .pull_up_sel(pull_up_sel), .line(line));
    tade_rx_model #(.BIT_CYC(8)) rx (.sys_clk(sys_clk), .rst(rst), .line(line),
        .local_addr(loc), .word(word), .word_v(word_v), .match(match), .payload_out(pout));
    // a floating pin reads back whatever weak pull is selected
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            pins.addr[i] = (am[i] == 2'h2) ? pull_up_sel.addr[i] : am[i][0];
        end
        for (int j = 0; j < 8; j++) begin
            pins.payload[j] = (pm[j] == 2'h2) ? pull_up_sel.payload[j] : pm[j][0];
        end
    end
    always @(posedge sys_clk) if (word_v === 1'b1) n_words++;
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    task cmp(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // bounded wait for the next decoded word, ends on a falling edge
    task wait_word;
        int i;
        for (i = 0; i < 3000 && word_v !== 1'b1; i++) @(negedge sys_clk);
        if (i == 3000) n_mismatch++;
        @(negedge sys_clk);
    endtask : wait_word
    task wait_idle;
        int i;
        for (i = 0; i < 3000 && line.active !== 1'b0; i++) @(negedge sys_clk);
        cmp(36'(line.active), 36'h0);
    endtask : wait_idle
    // request held high through reset sends straight away
    task t_power_up;
        wait_word();
        cmp(word, {pm, am});
        cmp(36'(pout), 36'h94);
    endtask : t_power_up
    // changes mid cycle show only in the next cycle, after three words
    task t_refresh;
        logic [15:0] old;
        old = pm;
        pm = 16'haaab;
        wait_word();
        cmp(word, {old, am});
        wait_word();
        cmp(word, {old, am});
        wait_word();
        cmp(word, {pm, am});
        cmp(36'(pout), 36'h01);
    endtask : t_refresh
    // dropping the request mid cycle still completes the cycle
    task t_fall;
        req = 0;
        wait_word();
        cmp(word, {pm, am});
        wait_word();
        cmp(word, {pm, am});
        wait_idle();
        cmp(36'(n_words), 36'h6);
    endtask : t_fall
    // floating versus low on one address input is a different address
    task t_mismatch;
        logic key;
        loc[3:2] = 2'h2;
        pm = 16'hffff;
        // keypad host: any payload input driven high raises the request
        key = 1'b0;
        for (int j = 0; j < 8; j++) begin
            key = key | (pm[j] == 2'h3);
        end
        req = key;
        wait_word();
        req = 0;
        cmp(word, {pm, am});
        cmp(36'(match), 36'h0);
        cmp(36'(pout), 36'h01);
        wait_idle();
    endtask : t_mismatch
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    // watchdog well past the four scenarios
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        rst = 1;
        req = 1;
        am = 20'hb3cb3;
        pm = 16'he3b8;
        loc = am;
        n_mismatch = 0;
        n_compared = 0;
        n_words = 0;
        repeat (16) @(negedge sys_clk);
        rst = 0;
        t_power_up();
        t_refresh();
        t_fall();
        t_mismatch();
        test_done();
    end
endmodule : tade_encoder_bench

// File: test/tade_rx_model.sv
`timescale 1ns/1ps
module tade_rx_model
    import tade_pkg::*;
#(
    parameter int unsigned BIT_CYC = 8
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // line from the encoder
    input  wire tade_line_s               line,
    // own address, one trit code per input
    input  wire logic [2*TADE_ADDR_W-1:0] local_addr,
    // decoded results
    output logic [TADE_SYMS-1:0]          word,
    output logic                          word_v,
    output logic                          match,
    output logic [TADE_DATA_W-1:0]        payload_out
);
    logic [TADE_SYMS-1:0] sr;
    int                   hi, lo, n;
    logic                 d_q;
    // pulse width decides a line bit; a long low gap restarts the word
    always @(posedge sys_clk) begin
        word_v <= 1'b0;
        d_q <= line.data;
        if (rst || !line.active) begin
            n <= 0;
            hi <= 0;
            lo <= 0;
        end else begin
            hi <= line.data ? hi + 1 : 0;
            lo <= line.data ? 0 : lo + 1;
            if (lo > 2 * BIT_CYC) n <= 0;
            if (d_q && !line.data) begin
                sr[n] <= (hi > BIT_CYC / 2);
                n <= n + 1;
                if (n == TADE_SYMS - 1) begin
                    word_v <= 1'b1;
                    word <= {hi > BIT_CYC / 2, sr[TADE_SYMS-2:0]};
                end
            end
        end
    end
    // match follows every word, payload_out only a word whose address matches; float reads low
    always @(posedge sys_clk) begin
        if (rst) begin
            match <= 1'b0;
            payload_out <= 8'h00;
        end else if (word_v) begin
            match <= (word[2*TADE_ADDR_W-1:0] === local_addr);
            if (word[2*TADE_ADDR_W-1:0] === local_addr) begin
                for (int j = 0; j < TADE_DATA_W; j++) begin
                    payload_out[j] <= word[2*TADE_ADDR_W+2*j +: 2] == TADE_TRIT_HIGH;
                end
            end
        end
    end
endmodule : tade_rx_model
